// [core/clms_pkg.sv]
package clms_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [3:0] CLMS_OFF_CTRL = 4'h0;
	localparam logic [3:0] CLMS_OFF_STATUS = 4'h4;

	// control word field positions
	localparam int CLMS_CTRL_EXT_GEN_ON = 0;
	localparam int CLMS_CTRL_INT_GEN_ON = 1;
	localparam int CLMS_CTRL_MONITOR_ON = 2;
	localparam int CLMS_CTRL_CLK_SEL = 3;
	localparam int CLMS_CTRL_SLOW_XTAL = 4;

	// status word field positions
	localparam int CLMS_STAT_EXT_STABLE = 0;
	localparam int CLMS_STAT_INT_STABLE = 1;
	localparam int CLMS_STAT_EXT_INACTIVE = 2;
	localparam int CLMS_STAT_INT_INACTIVE = 3;
	localparam int CLMS_STAT_EXT_SIDE = 4;
	localparam int CLMS_STAT_INT_SIDE = 5;

	// ---------------------------------------------------------------
	// divider ratios
	// ---------------------------------------------------------------
	localparam int CLMS_SETTLE_DIV = 4096;
	localparam int CLMS_EXT_LONG_DIV = 128;
	localparam int CLMS_INT_LONG_DIV = 16;
	localparam logic [11:0] CLMS_SETTLE_LAST = 12'(CLMS_SETTLE_DIV - 1);
	localparam logic [11:0] CLMS_EXT_LONG_LAST = 12'(CLMS_EXT_LONG_DIV - 1);
	localparam logic [11:0] CLMS_INT_LONG_LAST = 12'(CLMS_INT_LONG_DIV - 1);
	localparam logic [1:0] CLMS_MISS_LIMIT = 2'h2;
	localparam logic [1:0] CLMS_BAND_NEEDED = 2'h2;

	// control word
	typedef struct packed {
		logic slow_crystal_sel;
		logic clk_sel;
		logic monitor_on;
		logic int_gen_on;
		logic ext_gen_on;
	} clms_ctrl_t;

	localparam clms_ctrl_t CLMS_CTRL_RESET = '{slow_crystal_sel: 1'b0, clk_sel: 1'b0, monitor_on: 1'b0,
		int_gen_on: 1'b1, ext_gen_on: 1'b0};

	// status word
	typedef struct packed {
		logic int_side;
		logic ext_side;
		logic int_inactive;
		logic ext_inactive;
		logic int_stable;
		logic ext_stable;
	} clms_stat_t;

endpackage

// [core/clms_top.sv]
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - slow crystal bit lowers amplifier gain for 32-100 kHz, else 1-8 MHz gain.
// - amplifier enabled only with external generator on and stop mode off.
// - input path buffers crystal input into external clock, same enable.
// - monitor flags failure on stopped clock or clock below other reference/4.
// - monitor on sets only with both generators on and both stable.
// - monitor stays on when a clock later loses stability.
// - stable: external ref ext/(128*4) or ext/4, internal ref base/4 or base/64.
// - unstable: long divider makes settle clock ext/4096, external ref off.
// - long divider held reset while external generator enable clear.
// - external stable sets on settle clock falling edge after 4096 cycles.
// - later divider edges only reinforce the stable flag, never clear it.
// - external stable clears on generator off or external inactive.
// - external inactive returns long divider to settling, changing ref ratios.
// - internal detector: base fall each ext ref low; two misses set inactive.
// - internal stable after two in-band measurements; clears on fault or disable.
// - external detector: ext fall each int ref low; two misses set inactive.
// - select bit picks external or internal clock; output divided by two.
// - switch runs old clock 1-2 cycles, low 1-2 new cycles, glitch free.
// - reset forces internal clock selection.
// - with monitor on, inactive side forced deselected; active side follows.
// - external enable equals generator on and not stop; else clock low.
// - internal enable equals generator on and not stop.
// - select write ignored unless requested source on and stable.
module clms_top
	import clms_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// system and analog inputs
	input wire logic gen_stop,
	input wire logic xtal_in,
	input wire logic int_clk,
	input wire logic int_base_clk,
	input wire logic int_in_band,
	// oscillator controls
	output logic xtal_amp_en,
	output logic xtal_gain_slow,
	output logic ext_gen_en,
	output logic int_gen_en,
	// clock outputs
	output logic ext_clk,
	output logic ext_settle_clk,
	output logic ext_ref_clk,
	output logic int_ref_clk,
	output logic osc_out_clk,
	output logic gen_out_clk
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	clms_ctrl_t ctrl;
	clms_stat_t stat;
	logic ack;
	logic acc_wr;
	logic [3:0] in_raw;
	logic [3:0] in_filt;
	logic [3:0] in_prev;
	logic [3:0] in_fall;
	logic ext_fall;
	logic base_fall;
	logic int_clk_fall;
	logic band_ok;
	logic ext_stable;
	logic ext_stable_d;
	logic int_stable;
	logic [11:0] long_cnt;
	logic long_wrap_ext;
	logic long_wrap_int;
	logic settle_edge;
	logic ext_tick;
	logic int_tick;
	logic [1:0] ext_q;
	logic [1:0] int_q;
	logic [1:0] band_cnt;
	logic [1:0] ref_low;
	logic [1:0] ref_rise;
	logic [1:0] tgt_fall;
	logic [1:0] seen;
	logic [1:0] inactive;
	logic [1:0] miss [0:1];
	logic ext_ok;
	logic int_ok;
	logic e_s1;
	logic e_s2;
	logic i_s1;
	logic i_s2;
	logic osc_prev;
	logic [31:0] next_readdata;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	assign in_raw = {int_in_band, int_base_clk, int_clk, xtal_in};

	// three flops per input; a change counts once the last two agree
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_sync
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					in_filt[g] <= 1'b0;
					in_prev[g] <= 1'b0;
				end
				else
				begin
					s1 <= in_raw[g];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3)
						in_filt[g] <= s3;
					in_prev[g] <= in_filt[g];
				end
			end
			assign in_fall[g] = in_prev[g] & ~in_filt[g];
		end
	endgenerate

	// clocks are only seen while their generator is enabled
	assign ext_fall = in_fall[0] & ext_gen_en;
	assign int_clk_fall = in_fall[1] & int_gen_en;
	assign base_fall = in_fall[2] & int_gen_en;
	assign band_ok = in_filt[3];

	// ---------------------------------------------------------------
	// oscillator enables
	// ---------------------------------------------------------------
	// enables follow the control bits and stop mode; gain follows the crystal bit alone
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_gen_en <= 1'b0;
			int_gen_en <= 1'b0;
			xtal_amp_en <= 1'b0;
			xtal_gain_slow <= 1'b0;
			ext_clk <= 1'b0;
		end
		else
		begin
			ext_gen_en <= ctrl.ext_gen_on & ~gen_stop;
			int_gen_en <= ctrl.int_gen_on & ~gen_stop;
			xtal_amp_en <= ctrl.ext_gen_on & ~gen_stop;
			xtal_gain_slow <= ctrl.slow_crystal_sel;
			ext_clk <= in_filt[0] & ext_gen_en;
		end
	end

	// ---------------------------------------------------------------
	// long divider and references
	// ---------------------------------------------------------------
	assign settle_edge = ~ext_stable & ext_fall & (long_cnt == CLMS_SETTLE_LAST);
	assign long_wrap_ext = ext_stable & ~ctrl.slow_crystal_sel & ext_fall & (long_cnt == CLMS_EXT_LONG_LAST);
	assign long_wrap_int = ext_stable & ctrl.slow_crystal_sel & base_fall & (long_cnt == CLMS_INT_LONG_LAST);

	// long divider: settling on ext, then ext/128 or base/16
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			long_cnt <= 12'h000;
		else if (~ext_gen_en || ext_stable != ext_stable_d)
			long_cnt <= 12'h000;
		else if (~ext_stable)
		begin
			if (ext_fall)
				long_cnt <= long_cnt + 12'h001;
		end
		else if (long_wrap_ext || long_wrap_int)
			long_cnt <= 12'h000;
		else if (ctrl.slow_crystal_sel ? base_fall : ext_fall)
			long_cnt <= long_cnt + 12'h001;
	end

	// settle clock is the divider msb only while settling
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ext_settle_clk <= 1'b0;
		else
			ext_settle_clk <= ~ext_stable & long_cnt[11];
	end

	// ticks into the divide-by-four stages
	assign ext_tick = ext_stable & (ctrl.slow_crystal_sel ? ext_fall : long_wrap_ext);
	assign int_tick = (ext_stable & ctrl.slow_crystal_sel) ? long_wrap_int : base_fall;

	// divide-by-four stages; external reference off while settling
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_q <= 2'h0;
			int_q <= 2'h0;
		end
		else
		begin
			if (~ext_stable)
				ext_q <= 2'h0;
			else if (ext_tick)
				ext_q <= ext_q + 2'h1;
			if (~int_gen_en)
				int_q <= 2'h0;
			else if (int_tick)
				int_q <= int_q + 2'h1;
		end
	end

	// reference outputs from flops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_ref_clk <= 1'b0;
			int_ref_clk <= 1'b0;
			ext_stable_d <= 1'b0;
		end
		else
		begin
			ext_ref_clk <= ext_q[1];
			int_ref_clk <= int_q[1];
			ext_stable_d <= ext_stable;
		end
	end

	// ---------------------------------------------------------------
	// activity detectors
	// ---------------------------------------------------------------
	// index 0 watches the base clock, index 1 the external clock
	assign ref_low = {~int_q[1], ~ext_q[1]};
	assign ref_rise = {int_tick & (int_q == 2'h1), ext_tick & (ext_q == 2'h1)};
	assign tgt_fall = {ext_fall, base_fall};

	generate
		for (g = 0; g < 2; g++)
		begin : g_det
			logic seen_now;
			assign seen_now = seen[g] | (tgt_fall[g] & ref_low[g]);
			// two missed low phases set inactive, next edge clears it
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					seen[g] <= 1'b0;
					miss[g] <= 2'h0;
					inactive[g] <= 1'b0;
				end
				else if (~ctrl.monitor_on)
				begin
					seen[g] <= 1'b0;
					miss[g] <= 2'h0;
					inactive[g] <= 1'b0;
				end
				else if (ref_rise[g])
				begin
					seen[g] <= 1'b0;
					if (seen_now)
					begin
						miss[g] <= 2'h0;
						inactive[g] <= 1'b0;
					end
					else
					begin
						if (miss[g] != CLMS_MISS_LIMIT)
							miss[g] <= miss[g] + 2'h1;
						if (miss[g] + 2'h1 >= CLMS_MISS_LIMIT)
							inactive[g] <= 1'b1;
					end
				end
				else if (tgt_fall[g] & ref_low[g])
				begin
					seen[g] <= 1'b1;
					miss[g] <= 2'h0;
					inactive[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// stable flags
	// ---------------------------------------------------------------
	// external stable: set by settle edge, set wins over clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ext_stable <= 1'b0;
		else if (settle_edge)
			ext_stable <= 1'b1;
		else if (~ctrl.ext_gen_on || inactive[1])
			ext_stable <= 1'b0;
	end

	// in-band measurements once per internal reference period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			band_cnt <= 2'h0;
		else if (~int_gen_en || ~band_ok)
			band_cnt <= 2'h0;
		else if (int_tick && int_q == 2'h3 && band_cnt != CLMS_BAND_NEEDED)
			band_cnt <= band_cnt + 2'h1;
	end

	// internal stable after two in-band measurements
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_stable <= 1'b0;
		else if (~int_gen_en || ~band_ok || inactive[0])
			int_stable <= 1'b0;
		else if (band_cnt == CLMS_BAND_NEEDED)
			int_stable <= 1'b1;
	end

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	assign ext_ok = ctrl.ext_gen_on & ext_stable;
	assign int_ok = ctrl.int_gen_on & int_stable;
	assign acc_wr = avs_write & ack & (avs_address == CLMS_OFF_CTRL) & avs_byteenable[0];

	// generator and crystal bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl.ext_gen_on <= CLMS_CTRL_RESET.ext_gen_on;
			ctrl.int_gen_on <= CLMS_CTRL_RESET.int_gen_on;
			ctrl.slow_crystal_sel <= CLMS_CTRL_RESET.slow_crystal_sel;
		end
		else if (acc_wr)
		begin
			ctrl.ext_gen_on <= avs_writedata[CLMS_CTRL_EXT_GEN_ON];
			ctrl.int_gen_on <= avs_writedata[CLMS_CTRL_INT_GEN_ON];
			ctrl.slow_crystal_sel <= avs_writedata[CLMS_CTRL_SLOW_XTAL];
		end
	end

	// monitor on: sets only when both sides on and stable, then holds
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl.monitor_on <= CLMS_CTRL_RESET.monitor_on;
		else if (acc_wr)
			ctrl.monitor_on <= avs_writedata[CLMS_CTRL_MONITOR_ON]
				& (ctrl.monitor_on | (ext_ok & int_ok));
	end

	// source select: guarded writes, forced by the monitor
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl.clk_sel <= CLMS_CTRL_RESET.clk_sel;
		else if (ctrl.monitor_on && inactive[0])
			ctrl.clk_sel <= 1'b1;
		else if (ctrl.monitor_on && inactive[1])
			ctrl.clk_sel <= 1'b0;
		else if (acc_wr && avs_writedata[CLMS_CTRL_CLK_SEL] != ctrl.clk_sel)
		begin
			if (avs_writedata[CLMS_CTRL_CLK_SEL] ? ext_ok : int_ok)
				ctrl.clk_sel <= avs_writedata[CLMS_CTRL_CLK_SEL];
		end
	end

	// ---------------------------------------------------------------
	// glitch-free clock switch
	// ---------------------------------------------------------------
	// external side steps on external falls, gated by internal side
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			e_s1 <= 1'b0;
			e_s2 <= 1'b0;
		end
		else if (ctrl.monitor_on && inactive[1])
		begin
			e_s1 <= 1'b0;
			e_s2 <= 1'b0;
		end
		else if (ext_fall)
		begin
			e_s1 <= ctrl.clk_sel & ~i_s2;
			e_s2 <= e_s1;
		end
	end

	// internal side steps on internal clock falls, gated by external side
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			i_s1 <= 1'b1;
			i_s2 <= 1'b1;
		end
		else if (ctrl.monitor_on && inactive[0])
		begin
			i_s1 <= 1'b0;
			i_s2 <= 1'b0;
		end
		else if (int_clk_fall)
		begin
			i_s1 <= ~ctrl.clk_sel & ~e_s2;
			i_s2 <= i_s1;
		end
	end

	// selected clock out and divide by two on its rising edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			osc_out_clk <= 1'b0;
			osc_prev <= 1'b0;
			gen_out_clk <= 1'b0;
		end
		else
		begin
			osc_out_clk <= (e_s2 & in_filt[0] & ext_gen_en) | (i_s2 & in_filt[1] & int_gen_en);
			osc_prev <= osc_out_clk;
			if (osc_out_clk & ~osc_prev)
				gen_out_clk <= ~gen_out_clk;
		end
	end

	// ---------------------------------------------------------------
	// avalon-mm slave
	// ---------------------------------------------------------------
	assign stat = '{int_side: i_s2, ext_side: e_s2, int_inactive: inactive[0], ext_inactive: inactive[1],
		int_stable: int_stable, ext_stable: ext_stable};

	// read mux; unmapped offsets read zero
	always_comb
	begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			CLMS_OFF_CTRL: next_readdata = {27'h000_0000, ctrl};
			CLMS_OFF_STATUS: next_readdata = {26'h000_0000, stat};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// one wait cycle per access; read data captured during it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			ack <= (avs_read | avs_write) & ~ack;
			if (avs_read & ~ack)
				avs_readdata <= next_readdata;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

endmodule

// [dv/clms_monitor.sv]
`timescale 1ns/100ps
module clms_monitor
	import clms_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// controls and clocks
	input wire logic gen_stop,
	input wire logic xtal_gain_slow,
	input wire logic ext_gen_en,
	input wire logic int_gen_en,
	input wire logic ext_clk,
	input wire logic ext_settle_clk,
	input wire logic ext_ref_clk,
	input wire logic osc_out_clk,
	input wire logic gen_out_clk
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// control write taken at this edge
	logic ctrl_wr;
	assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == CLMS_OFF_CTRL && avs_byteenable[0];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	a_read_unmapped: assert property (avs_read && !avs_waitrequest && avs_address != CLMS_OFF_CTRL
		&& avs_address != CLMS_OFF_STATUS |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:6] == 26'h0)
		else $error("upper read bits not zero");
	a_stop_gates: assert property (gen_stop |=> !ext_gen_en && !int_gen_en)
		else $error("generator enable high in stop mode");
	a_gen_follow: assert property ((ctrl_wr && !gen_stop) ##1 !gen_stop |=>
		ext_gen_en == $past(avs_writedata[CLMS_CTRL_EXT_GEN_ON], 2)
		&& int_gen_en == $past(avs_writedata[CLMS_CTRL_INT_GEN_ON], 2)) else $error("enable not following on bit");
	a_gain_follow: assert property (ctrl_wr |-> ##2 xtal_gain_slow == $past(avs_writedata[CLMS_CTRL_SLOW_XTAL], 2))
		else $error("gain select not following control bit");
	a_ext_clk_low: assert property (!ext_gen_en [*3] |-> !ext_clk)
		else $error("external clock runs while disabled");
	a_settle_reset: assert property (!ext_gen_en [*3] |-> !ext_settle_clk)
		else $error("long divider runs while disabled");
	a_ref_quiet: assert property (ext_settle_clk |-> !ext_ref_clk)
		else $error("external reference runs while settling");
	a_out_halves: assert property ($rose(osc_out_clk) |-> ##[0:1] $changed(gen_out_clk))
		else $error("bus clock source missed a toggle");
endmodule

bind clms_top clms_monitor u_mon (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gen_stop(gen_stop),
	.xtal_gain_slow(xtal_gain_slow), .ext_gen_en(ext_gen_en), .int_gen_en(int_gen_en), .ext_clk(ext_clk),
	.ext_settle_clk(ext_settle_clk), .ext_ref_clk(ext_ref_clk), .osc_out_clk(osc_out_clk),
	.gen_out_clk(gen_out_clk));

// [dv/clms_xtal_model.sv]
`timescale 1ns/100ps
module clms_xtal_model
(
	// controls
	input wire logic xtal_amp_en,
	input wire logic stall,
	// pin
	output logic xtal_in
);
	// ---------------------------------------------------------------
	// crystal
	// ---------------------------------------------------------------
	// swings only while the amplifier runs; a lost crystal parks the pin low
	initial xtal_in = 1'b0;
	always
	begin
		#40;
		if (xtal_amp_en && !stall)
			xtal_in = ~xtal_in;
		else
			xtal_in = 1'b0;
	end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
	import clms_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	typedef struct packed {logic wr; logic [3:0] addr; logic [31:0] data; logic [31:0] exp;} clms_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic gen_stop = 1'b0;
	logic int_clk = 1'b0;
	logic int_base_clk = 1'b0;
	logic int_in_band = 1'b0;
	logic xtal_stall = 1'b0;
	logic base_stall = 1'b0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, xtal_in, xtal_amp_en, xtal_gain_slow, ext_gen_en, int_gen_en;
	logic ext_clk, ext_settle_clk, ext_ref_clk, int_ref_clk, osc_out_clk, gen_out_clk;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int ext_falls = 0;
	int base_falls = 0;
	// refused writes, unmapped place, accepted control word
	clms_row_t rows [10] = '{'{1'b0, CLMS_OFF_CTRL, 32'h0, 32'h2}, '{1'b0, 4'h8, 32'h0, 32'h0},
		'{1'b1, CLMS_OFF_CTRL, 32'ha, 32'h0}, '{1'b0, CLMS_OFF_CTRL, 32'h0, 32'h2},
		'{1'b1, CLMS_OFF_CTRL, 32'h6, 32'h0}, '{1'b0, CLMS_OFF_CTRL, 32'h0, 32'h2},
		'{1'b1, CLMS_OFF_CTRL, 32'h13, 32'h0}, '{1'b0, CLMS_OFF_CTRL, 32'h0, 32'h13},
		'{1'b1, 4'h8, 32'h0, 32'h0}, '{1'b0, CLMS_OFF_CTRL, 32'h0, 32'h13}};

	// ---------------------------------------------------------------
	// clocks, pin sources and timeout
	// ---------------------------------------------------------------
	always #5 clk = ~clk;
	always #35 int_clk = ~int_clk;
	always #55 if (!base_stall) int_base_clk = ~int_base_clk;
	always @(negedge ext_clk) ext_falls++;
	always @(negedge int_base_clk) base_falls++;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			fail_count++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// design and crystal
	// ---------------------------------------------------------------
	clms_top DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .gen_stop(gen_stop), .xtal_in(xtal_in), .int_clk(int_clk),
		.int_base_clk(int_base_clk), .int_in_band(int_in_band), .xtal_amp_en(xtal_amp_en),
		.xtal_gain_slow(xtal_gain_slow), .ext_gen_en(ext_gen_en), .int_gen_en(int_gen_en), .ext_clk(ext_clk),
		.ext_settle_clk(ext_settle_clk), .ext_ref_clk(ext_ref_clk), .int_ref_clk(int_ref_clk),
		.osc_out_clk(osc_out_clk), .gen_out_clk(gen_out_clk));
	clms_xtal_model u_xtal (.xtal_amp_en(xtal_amp_en), .stall(xtal_stall), .xtal_in(xtal_in));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data, output logic [31:0] q);
		@(posedge clk);
		avs_address <= addr;
		avs_writedata <= data;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(negedge clk);
		while (avs_waitrequest !== 1'b0);
		@(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// poll a status bit until it reaches a level
	task automatic wait_status(input int bitn, input logic val, input int n, output logic [31:0] q);
		int k;
		k = 0;
		do
		begin
			bus(1'b0, CLMS_OFF_STATUS, 32'h0, q);
			k++;
		end
		while (q[bitn] !== val && k < n);
		check("status bit", 32'(q[bitn]), 32'(val));
	endtask

	task automatic results;
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		int_in_band <= 1'b1;
		foreach (rows[i])
		begin
			bus(rows[i].wr, rows[i].addr, rows[i].data, rd);
			if (!rows[i].wr)
				check("row read", rd, rows[i].exp);
		end
		check("gain slow", 32'(xtal_gain_slow), 32'h1);
		check("amp on", 32'(xtal_amp_en), 32'h1);
		gen_stop <= 1'b1;
		repeat (4) @(posedge clk);
		check("stop", 32'({xtal_amp_en, ext_gen_en, int_gen_en, ext_clk}), 32'h0);
		gen_stop <= 1'b0;
		ext_falls = 0;
		wait_status(CLMS_STAT_EXT_STABLE, 1'b1, 20000, rd);
		check("settle count", 32'(ext_falls >= 4093 && ext_falls <= 4100), 32'h1);
		// slow crystal ratios first, then the fast ones
		@(posedge ext_ref_clk);
		ext_falls = 0;
		@(posedge ext_ref_clk);
		check("ext ref slow", 32'(ext_falls), 32'h4);
		@(posedge int_ref_clk);
		base_falls = 0;
		@(posedge int_ref_clk);
		check("int ref slow", 32'(base_falls), 32'h40);
		bus(1'b1, CLMS_OFF_CTRL, 32'h3, rd);
		repeat (3) @(posedge clk);
		check("gain fast", 32'(xtal_gain_slow), 32'h0);
		@(posedge ext_ref_clk);
		ext_falls = 0;
		@(posedge ext_ref_clk);
		check("ext ref ratio", 32'(ext_falls), 32'h200);
		@(posedge int_ref_clk);
		base_falls = 0;
		@(posedge int_ref_clk);
		check("int ref ratio", 32'(base_falls), 32'h4);
		wait_status(CLMS_STAT_INT_STABLE, 1'b1, 300, rd);
		bus(1'b1, CLMS_OFF_CTRL, 32'hb, rd);
		wait_status(CLMS_STAT_EXT_SIDE, 1'b1, 50, rd);
		check("sides ext", 32'(rd[5:4]), 32'h1);
		@(posedge gen_out_clk);
		ext_falls = 0;
		@(posedge gen_out_clk);
		check("out halves", 32'(ext_falls), 32'h2);
		bus(1'b1, CLMS_OFF_CTRL, 32'hf, rd);
		bus(1'b0, CLMS_OFF_CTRL, 32'h0, rd);
		check("monitor on", rd, 32'hf);
		base_stall <= 1'b1;
		wait_status(CLMS_STAT_INT_INACTIVE, 1'b1, 5000, rd);
		check("int lost", 32'({rd[5:4], rd[1]}), 32'h2);
		base_stall <= 1'b0;
		wait_status(CLMS_STAT_INT_INACTIVE, 1'b0, 3000, rd);
		wait_status(CLMS_STAT_INT_STABLE, 1'b1, 300, rd);
		xtal_stall <= 1'b1;
		wait_status(CLMS_STAT_EXT_INACTIVE, 1'b1, 300, rd);
		wait_status(CLMS_STAT_INT_SIDE, 1'b1, 50, rd);
		check("ext lost", 32'({rd[5:4], rd[0]}), 32'h4);
		bus(1'b0, CLMS_OFF_CTRL, 32'h0, rd);
		check("monitor held", 32'(rd[CLMS_CTRL_MONITOR_ON]), 32'h1);
		xtal_stall <= 1'b0;
		wait_status(CLMS_STAT_EXT_INACTIVE, 1'b0, 50, rd);
		bus(1'b1, CLMS_OFF_CTRL, 32'h3, rd);
		bus(1'b0, CLMS_OFF_STATUS, 32'h0, rd);
		check("resettling", 32'(rd[CLMS_STAT_EXT_STABLE]), 32'h0);
		// reset in mid-run goes back to the internal side
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, CLMS_OFF_CTRL, 32'h0, rd);
		check("reset ctrl", rd, 32'h2);
		bus(1'b0, CLMS_OFF_STATUS, 32'h0, rd);
		check("reset side", 32'(rd[5:4]), 32'h2);
		results();
	end
endmodule
